// ==== design/phy_pin_pkg.sv ====
`default_nettype none
package phy_pin_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_IRQ_SRC = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  // Control fields.
  localparam int CTRL_MODE3 = 0;
  localparam int CTRL_DUPLEX = 1;
  localparam int CTRL_PIN_IRQ = 2;
  // Interrupt status fields.
  localparam int IRQ_LINK = 0;
  localparam int IRQ_SPEED = 1;
  localparam int IRQ_PD = 2;
  localparam int IRQ_SRC = 3;
  localparam int IRQ_W = 4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int MII_MHZ = 25;
  localparam int RMII_MHZ = 50;
  localparam int MII_PER = CLK_MHZ / MII_MHZ;
  localparam int RMII_PER = CLK_MHZ / RMII_MHZ;
  typedef enum logic [1:0] {LED_M1, LED_M2, LED_M3} led_mode_t;
endpackage
`default_nettype wire

// ==== design/blink_div.sv ====
`default_nettype none
module blink_div
  import phy_pin_pkg::*;
#(
  parameter int PERIOD = BLINK_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_ff >= 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== design/mac_clk_gen.sv ====
`default_nettype none
module mac_clk_gen
  import phy_pin_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rmii,
  input wire logic en,
  output logic clk_out
);
  // Output is a divided copy of the system clock; held low when disabled.
  // An odd period keeps the rate exact at the cost of duty: three high, two low.
  logic [7:0] cnt_ff;
  logic [7:0] period;
  logic [7:0] high_len;
  assign period = rmii ? 8'(RMII_PER) : 8'(MII_PER);
  assign high_len = period - (period >> 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 8'h00;
      clk_out <= 1'b0;
    end else if (!en) begin
      cnt_ff <= 8'h00;
      clk_out <= 1'b0;
    end else begin
      clk_out <= cnt_ff < high_len;
      if (cnt_ff >= period - 8'h01) begin
        cnt_ff <= 8'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/phy_status_pin_logic.sv ====
// Added by the designer: register access over APB and the placing of the registers.
`default_nettype none
// What this block does
// - Mode 1: link indicator lit while link is good.
// - Modes 2 and 3: link indicator lit on link, blinks on activity.
// - Speed indicator lit at 100 Mb/s, dark at 10 Mb/s, any mode.
// - Mode 1: activity/collision indicator lit on tx or rx activity.
// - Mode 2: activity/collision indicator shows collision.
// - Mode 3: activity/collision indicator may show full duplex instead.
// - Strap picks LED mode 1 or 2.
// - Each LED lit level is opposite to its strapped reset level.
// - Straps sampled during reset, held afterwards.
// - Reset returns every register to its default.
// - Reset re-samples and re-applies all straps.
// - Shared pin defaults to active-low power-down input.
// - In interrupt function shared pin is open drain, low while pending.
// - Shared pin changes function only by register write.
// - MAC clock 25 MHz in MII, 50 MHz in RMII.
// - Disable strap keeps MAC clock output quiet.
module phy_status_pin_logic
  import phy_pin_pkg::*;
#(
  parameter int NPORT = 2,
  parameter int BLINK_PERIOD = BLINK_CYC
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Port status from the transceiver.
  input wire logic [NPORT-1:0] LINK_UP,
  input wire logic [NPORT-1:0] SPEED_100,
  input wire logic [NPORT-1:0] FULL_DUPLEX,
  input wire logic [NPORT-1:0] TX_ACT,
  input wire logic [NPORT-1:0] RX_ACT,
  input wire logic [NPORT-1:0] COLLISION,
  input wire logic [NPORT-1:0] IRQ_COND,
  // Straps, levels of the strap pins while reset is held.
  input wire logic LED_MODE_STRAP,
  input wire logic RMII_STRAP,
  input wire logic MAC_CLK_DIS_STRAP,
  // LED pins, polarity strapped by the pin's own reset level.
  input wire logic [NPORT-1:0] LINK_IND_I,
  output logic [NPORT-1:0] LINK_IND_O,
  output logic [NPORT-1:0] LINK_IND_OE,
  input wire logic [NPORT-1:0] SPEED_IND_I,
  output logic [NPORT-1:0] SPEED_IND_O,
  output logic [NPORT-1:0] SPEED_IND_OE,
  input wire logic [NPORT-1:0] ACT_COL_IND_I,
  output logic [NPORT-1:0] ACT_COL_IND_O,
  output logic [NPORT-1:0] ACT_COL_IND_OE,
  // Shared power-down / interrupt pin.
  input wire logic [NPORT-1:0] PD_IRQ_PIN_I,
  output logic [NPORT-1:0] PD_IRQ_PIN_O,
  output logic [NPORT-1:0] PD_IRQ_PIN_OE,
  // System side.
  output logic [NPORT-1:0] POWER_DOWN,
  output logic MAC_CLK_OUT,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Pins are sampled while reset is low, since a constant is all an
  // asynchronous reset may load; the first free edge takes one last sample.
  logic in_rst_ff;
  logic led_mode2_ff;
  logic rmii_ff;
  logic clk_dis_ff;
  logic [NPORT-1:0] pol_link_ff;
  logic [NPORT-1:0] pol_speed_ff;
  logic [NPORT-1:0] pol_act_ff;
  logic sampling;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      in_rst_ff <= 1'b1;
    end else begin
      in_rst_ff <= 1'b0;
    end
  end
  assign sampling = in_rst_ff;
  always_ff @(posedge CLK_SYS) begin
    if (sampling) begin
      led_mode2_ff <= LED_MODE_STRAP;
      rmii_ff <= RMII_STRAP;
      clk_dis_ff <= MAC_CLK_DIS_STRAP;
      pol_link_ff <= LINK_IND_I;
      pol_speed_ff <= SPEED_IND_I;
      pol_act_ff <= ACT_COL_IND_I;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [NPORT-1:0] src_ff;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [IRQ_W-1:0] event_set;
  led_mode_t led_mode;
  assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
  assign rd_en = PSEL && PENABLE && !PWRITE && PREADY;
  assign mapped = PADDR == OFS_CTRL || PADDR == OFS_STAT || PADDR == OFS_IRQ_STAT ||
    PADDR == OFS_IRQ_MASK || PADDR == OFS_IRQ_SRC;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= CTRL_RST;
      irq_mask_ff <= IRQ_W'(MASK_RST);
    end else if (wr_en) begin
      if (PADDR == OFS_CTRL) begin
        ctrl_ff <= {29'h00000000, PWDATA[2:0]};
      end
      if (PADDR == OFS_IRQ_MASK) begin
        irq_mask_ff <= PWDATA[IRQ_W-1:0];
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      src_ff <= '0;
    end else if (wr_en && PADDR == OFS_IRQ_SRC) begin
      src_ff <= (src_ff & ~PWDATA[NPORT-1:0]) | IRQ_COND;
    end else begin
      src_ff <= src_ff | IRQ_COND;
    end
  end
  // Setting wins over a write-one clear in the same cycle.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_ff <= '0;
    end else if (wr_en && PADDR == OFS_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~PWDATA[IRQ_W-1:0]) | event_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | event_set;
    end
  end
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (PADDR)
          OFS_CTRL: PRDATA <= ctrl_ff;
          OFS_STAT: PRDATA <= {24'h000000, 2'(led_mode), 1'b0, rmii_ff, clk_dis_ff,
            3'(POWER_DOWN)};
          OFS_IRQ_STAT: PRDATA <= 32'(irq_stat_ff);
          OFS_IRQ_MASK: PRDATA <= 32'(irq_mask_ff);
          OFS_IRQ_SRC: PRDATA <= 32'(src_ff);
          default: PRDATA <= 32'h00000000;
        endcase
      end else if (rd_en) begin
        PRDATA <= PRDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // LED logic
  // ----------------------------------------------------------------
  logic blink_tick;
  logic blink_ff;
  always_comb begin
    if (ctrl_ff[CTRL_MODE3]) begin
      led_mode = LED_M3;
    end else if (led_mode2_ff) begin
      led_mode = LED_M2;
    end else begin
      led_mode = LED_M1;
    end
  end
  blink_div #(
    .PERIOD(BLINK_PERIOD)
  ) u_blink (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .tick(blink_tick)
  );
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      blink_ff <= 1'b0;
    end else if (blink_tick) begin
      blink_ff <= ~blink_ff;
    end
  end

  logic [NPORT-1:0] lit_link;
  logic [NPORT-1:0] lit_act;
  logic [NPORT-1:0] link_d_ff;
  logic [NPORT-1:0] speed_d_ff;
  logic [NPORT-1:0] pd_in;
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      always_comb begin
        unique case (led_mode)
          LED_M1: begin
            lit_link[g] = LINK_UP[g];
            lit_act[g] = TX_ACT[g] | RX_ACT[g];
          end
          LED_M2: begin
            lit_link[g] = LINK_UP[g] & ~((TX_ACT[g] | RX_ACT[g]) & blink_ff);
            lit_act[g] = COLLISION[g];
          end
          default: begin
            lit_link[g] = LINK_UP[g] & ~((TX_ACT[g] | RX_ACT[g]) & blink_ff);
            lit_act[g] = ctrl_ff[CTRL_DUPLEX] ? FULL_DUPLEX[g] : COLLISION[g];
          end
        endcase
      end
      // A pin pulled up at reset lights by driving low, and the reverse.
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          LINK_IND_O[g] <= 1'b0;
          SPEED_IND_O[g] <= 1'b0;
          ACT_COL_IND_O[g] <= 1'b0;
          LINK_IND_OE[g] <= 1'b0;
          SPEED_IND_OE[g] <= 1'b0;
          ACT_COL_IND_OE[g] <= 1'b0;
        end else if (sampling) begin
          LINK_IND_OE[g] <= 1'b0;
          SPEED_IND_OE[g] <= 1'b0;
          ACT_COL_IND_OE[g] <= 1'b0;
        end else begin
          LINK_IND_O[g] <= lit_link[g] ^ pol_link_ff[g];
          SPEED_IND_O[g] <= SPEED_100[g] ^ pol_speed_ff[g];
          ACT_COL_IND_O[g] <= lit_act[g] ^ pol_act_ff[g];
          LINK_IND_OE[g] <= 1'b1;
          SPEED_IND_OE[g] <= 1'b1;
          ACT_COL_IND_OE[g] <= 1'b1;
        end
      end
      assign pd_in[g] = ~ctrl_ff[CTRL_PIN_IRQ] & ~PD_IRQ_PIN_I[g];
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          PD_IRQ_PIN_O[g] <= 1'b0;
          PD_IRQ_PIN_OE[g] <= 1'b0;
          POWER_DOWN[g] <= 1'b0;
        end else begin
          PD_IRQ_PIN_O[g] <= 1'b0;
          PD_IRQ_PIN_OE[g] <= ctrl_ff[CTRL_PIN_IRQ] & src_ff[g];
          POWER_DOWN[g] <= pd_in[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      link_d_ff <= '0;
      speed_d_ff <= '0;
    end else begin
      link_d_ff <= LINK_UP;
      speed_d_ff <= SPEED_100;
    end
  end
  // The delay stages still hold zero on the release edge, so a change seen there is false.
  assign event_set[IRQ_LINK] = ~sampling & (|(link_d_ff ^ LINK_UP));
  assign event_set[IRQ_SPEED] = ~sampling & (|(speed_d_ff ^ SPEED_100));
  assign event_set[IRQ_PD] = |(pd_in & ~POWER_DOWN);
  assign event_set[IRQ_SRC] = |IRQ_COND;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // MAC clock
  // ----------------------------------------------------------------
  // The divider gives exact rates only because 250 MHz is a multiple of 50 MHz.
  mac_clk_gen u_mac_clk (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .rmii(rmii_ff),
    .en(~clk_dis_ff & ~sampling),
    .clk_out(MAC_CLK_OUT)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SPEED: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && !$past(sampling) |-> SPEED_IND_O == ($past(SPEED_100) ^ pol_speed_ff))
    else $error("Speed indicator wrong.");
  AST_MODE1_LINK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && led_mode == LED_M1 |=> LINK_IND_O == ($past(LINK_UP) ^ pol_link_ff))
    else $error("Mode 1 link indicator wrong.");
  AST_MODE1_ACT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && led_mode == LED_M1 |=>
    ACT_COL_IND_O == ($past(TX_ACT | RX_ACT) ^ pol_act_ff))
    else $error("Mode 1 activity indicator wrong.");
  AST_MODE2_COL: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && led_mode == LED_M2 |=> ACT_COL_IND_O == ($past(COLLISION) ^ pol_act_ff))
    else $error("Mode 2 collision indicator wrong.");
  AST_LINK_DARK: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && led_mode != LED_M1 && LINK_UP == '0 |=> LINK_IND_O == pol_link_ff)
    else $error("Link indicator lit without link.");
  AST_MODE3_SEL: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !sampling && ctrl_ff[CTRL_MODE3] |=>
    ACT_COL_IND_O == ($past(ctrl_ff[CTRL_DUPLEX] ? FULL_DUPLEX : COLLISION) ^ pol_act_ff))
    else $error("Mode 3 activity or collision indicator wrong.");
  AST_PIN_INPUT: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !ctrl_ff[CTRL_PIN_IRQ] && !$past(ctrl_ff[CTRL_PIN_IRQ]) |-> PD_IRQ_PIN_OE == '0)
    else $error("Shared pin driven in power-down function.");
  AST_PIN_IRQ: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    ctrl_ff[CTRL_PIN_IRQ] |=> PD_IRQ_PIN_OE == $past(src_ff) && PD_IRQ_PIN_O == '0)
    else $error("Shared pin not pulled low on pending interrupt.");
  AST_CLK_QUIET: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    clk_dis_ff && !sampling |=> !MAC_CLK_OUT)
    else $error("MAC clock toggles while disabled.");
  // A five-cycle RMII period is split three high and two low.
  AST_CLK_RATE: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !clk_dis_ff && !sampling && rmii_ff && $rose(MAC_CLK_OUT) |->
    MAC_CLK_OUT[*3] ##1 !MAC_CLK_OUT[*2] ##1 MAC_CLK_OUT)
    else $error("MAC clock rate wrong.");
  AST_CLK_MII: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !clk_dis_ff && !sampling && !rmii_ff && $rose(MAC_CLK_OUT) |->
    MAC_CLK_OUT[*5] ##1 !MAC_CLK_OUT[*5] ##1 MAC_CLK_OUT)
    else $error("MAC clock rate wrong in MII mode.");
endmodule
`default_nettype wire

// ==== bench/phy_pin_partner.sv ====
`default_nettype none
// ----------
// Board side of the pins: strap resistors, LEDs and the shared pin pull-up.
// ----------
module phy_pin_partner #(
  parameter logic [1:0] LED_PULL = 2'h1
) (
  // LED pins.
  input wire logic [1:0] LINK_IND_O,
  input wire logic [1:0] LINK_IND_OE,
  output logic [1:0] LINK_IND_I,
  input wire logic [1:0] SPEED_IND_O,
  input wire logic [1:0] SPEED_IND_OE,
  output logic [1:0] SPEED_IND_I,
  input wire logic [1:0] ACT_COL_IND_O,
  input wire logic [1:0] ACT_COL_IND_OE,
  output logic [1:0] ACT_COL_IND_I,
  // Shared pin and the board's power-down switch.
  input wire logic [1:0] PD_IRQ_PIN_O,
  input wire logic [1:0] PD_IRQ_PIN_OE,
  input wire logic [1:0] PD_LOW,
  output logic [1:0] PD_IRQ_PIN_I
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven LED pin shows its strap resistor, never a stale value.
  assign LINK_IND_I = (LINK_IND_OE & LINK_IND_O) | (~LINK_IND_OE & LED_PULL);
  assign SPEED_IND_I = (SPEED_IND_OE & SPEED_IND_O) | (~SPEED_IND_OE & LED_PULL);
  assign ACT_COL_IND_I = (ACT_COL_IND_OE & ACT_COL_IND_O) | (~ACT_COL_IND_OE & LED_PULL);
  // Wired low by either party, otherwise pulled up.
  assign PD_IRQ_PIN_I = ~((PD_IRQ_PIN_OE & ~PD_IRQ_PIN_O) | PD_LOW);
endmodule
`default_nettype wire

// ==== bench/tb_phy_status_pin_logic.sv ====
`default_nettype none
module tb_phy_status_pin_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_pin_pkg::*;
  localparam logic [1:0] PULL = 2'h1;
  localparam int RST_CYC = 250;
  logic CLK_SYS, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, MAC_CLK_OUT, IRQ, err;
  logic LED_MODE_STRAP, RMII_STRAP, MAC_CLK_DIS_STRAP;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [1:0] LINK_UP, SPEED_100, FULL_DUPLEX, TX_ACT, RX_ACT, COLLISION, IRQ_COND, PD_LOW;
  logic [1:0] LINK_IND_I, LINK_IND_O, LINK_IND_OE, SPEED_IND_I, SPEED_IND_O, SPEED_IND_OE;
  logic [1:0] ACT_COL_IND_I, ACT_COL_IND_O, ACT_COL_IND_OE, PD_IRQ_PIN_I, PD_IRQ_PIN_O;
  logic [1:0] PD_IRQ_PIN_OE, POWER_DOWN;
  int failures, tests_run;
  phy_status_pin_logic #(.NPORT(2), .BLINK_PERIOD(8)) dut (.CLK_SYS, .ARST_N, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .LINK_UP, .SPEED_100,
    .FULL_DUPLEX, .TX_ACT, .RX_ACT, .COLLISION, .IRQ_COND, .LED_MODE_STRAP, .RMII_STRAP,
    .MAC_CLK_DIS_STRAP, .LINK_IND_I, .LINK_IND_O, .LINK_IND_OE, .SPEED_IND_I, .SPEED_IND_O,
    .SPEED_IND_OE, .ACT_COL_IND_I, .ACT_COL_IND_O, .ACT_COL_IND_OE, .PD_IRQ_PIN_I,
    .PD_IRQ_PIN_O, .PD_IRQ_PIN_OE, .POWER_DOWN, .MAC_CLK_OUT, .IRQ);
  phy_pin_partner #(.LED_PULL(PULL)) far (.LINK_IND_O, .LINK_IND_OE, .LINK_IND_I,
    .SPEED_IND_O, .SPEED_IND_OE, .SPEED_IND_I, .ACT_COL_IND_O, .ACT_COL_IND_OE,
    .ACT_COL_IND_I, .PD_IRQ_PIN_O, .PD_IRQ_PIN_OE, .PD_LOW, .PD_IRQ_PIN_I);
  // ----------
  // Shared tasks
  // ----------
  task automatic final_report();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    failures++;
    $display("BAD %s exp answer got timeout", nm);
    final_report();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) hang("pready");
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Straps are held through reset and left in place afterwards.
  task automatic rst(input logic m2, input logic rm, input logic dis);
    LED_MODE_STRAP <= m2;
    RMII_STRAP <= rm;
    MAC_CLK_DIS_STRAP <= dis;
    ARST_N <= 1'b0;
    cyc(RST_CYC);
    ARST_N <= 1'b1;
    cyc(2);
  endtask
  task automatic meas(output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    n = 0;
    while (MAC_CLK_OUT !== 1'b0 && n < 60) begin cyc(1); n++; end
    while (MAC_CLK_OUT !== 1'b1 && n < 60) begin cyc(1); n++; end
    while (MAC_CLK_OUT === 1'b1 && n < 60) begin cyc(1); hi++; n++; end
    while (MAC_CLK_OUT === 1'b0 && n < 60) begin cyc(1); lo++; n++; end
    if (n >= 60) hang("mac clock");
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs(input logic m2, input logic rm, input logic dis);
    rst(m2, rm, dis);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", CTRL_RST, rd);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", MASK_RST, rd);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat", {24'h0, 1'b0, m2, 1'b0, rm, dis, 3'h0}, rd);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped rd", 32'h0, rd);
    chk("led oe", 32'h3, {30'h0, LINK_IND_OE & SPEED_IND_OE & ACT_COL_IND_OE});
    apb(1'b1, OFS_CTRL, 32'h7);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl wr", 32'h7, rd);
    apb(1'b1, OFS_IRQ_MASK, 32'hF);
  endtask
  task automatic t_mode1();
    rst(1'b0, 1'b0, 1'b0);
    LINK_UP <= 2'h1;
    SPEED_100 <= 2'h2;
    TX_ACT <= 2'h1;
    RX_ACT <= 2'h2;
    cyc(3);
    chk("link", 2'h1 ^ PULL, LINK_IND_O);
    chk("speed", 2'h2 ^ PULL, SPEED_IND_O);
    chk("act", 2'h3 ^ PULL, ACT_COL_IND_O);
    TX_ACT <= 2'h0;
    RX_ACT <= 2'h0;
    cyc(3);
    chk("act idle", 2'h0 ^ PULL, ACT_COL_IND_O);
  endtask
  task automatic t_mode2();
    logic [1:0] lit, dark;
    lit = 2'h0;
    dark = 2'h0;
    rst(1'b1, 1'b0, 1'b0);
    LINK_UP <= 2'h3;
    SPEED_100 <= 2'h1;
    TX_ACT <= 2'h1;
    COLLISION <= 2'h2;
    cyc(3);
    chk("col", 2'h2 ^ PULL, ACT_COL_IND_O);
    chk("speed m2", 2'h1 ^ PULL, SPEED_IND_O);
    repeat (24) begin
      cyc(1);
      lit = lit | (LINK_IND_O ^ PULL);
      dark = dark | ~(LINK_IND_O ^ PULL);
    end
    chk("blink lit", 2'h3, lit);
    chk("blink dark", 2'h1, dark);
  endtask
  task automatic t_mode3();
    FULL_DUPLEX <= 2'h1;
    apb(1'b1, OFS_CTRL, 32'h3);
    cyc(3);
    chk("duplex", 2'h1 ^ PULL, ACT_COL_IND_O);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("mode3", 32'h2, {30'h0, rd[7:6]});
    apb(1'b1, OFS_CTRL, 32'h0);
    cyc(3);
    chk("back m2", 2'h2 ^ PULL, ACT_COL_IND_O);
  endtask
  task automatic t_pin();
    rst(1'b0, 1'b0, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    PD_LOW <= 2'h1;
    IRQ_COND <= 2'h2;
    cyc(4);
    IRQ_COND <= 2'h0;
    chk("pd", 32'h1, POWER_DOWN);
    chk("irq", 32'h1, IRQ);
    chk("pin oe", 32'h0, PD_IRQ_PIN_OE);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat", 32'hC, rd);
    PD_LOW <= 2'h0;
    apb(1'b1, OFS_IRQ_STAT, 32'h4);
    cyc(3);
    chk("irq clr", 32'h0, IRQ);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat w1c", 32'h8, rd);
    apb(1'b1, OFS_CTRL, 32'h4);
    cyc(2);
    chk("pin pull", 32'h2, PD_IRQ_PIN_OE);
    chk("pin wire", 32'h1, PD_IRQ_PIN_I);
    apb(1'b1, OFS_IRQ_SRC, 32'h2);
    cyc(2);
    chk("pin rel", 32'h0, PD_IRQ_PIN_OE);
  endtask
  task automatic t_clk();
    int hi, lo, moves;
    logic v;
    rst(1'b0, 1'b0, 1'b0);
    meas(hi, lo);
    chk("mii", 32'h5_0005, {hi[15:0], lo[15:0]});
    rst(1'b0, 1'b1, 1'b0);
    meas(hi, lo);
    chk("rmii", 32'h3_0002, {hi[15:0], lo[15:0]});
    rst(1'b0, 1'b0, 1'b1);
    moves = 0;
    v = MAC_CLK_OUT;
    repeat (40) begin
      cyc(1);
      if (MAC_CLK_OUT !== v) moves++;
    end
    chk("quiet", 32'h0, moves);
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    ARST_N = 1'b0;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 43'h0;
    {LINK_UP, SPEED_100, FULL_DUPLEX, TX_ACT, RX_ACT, COLLISION, IRQ_COND, PD_LOW} = 16'h0;
    {LED_MODE_STRAP, RMII_STRAP, MAC_CLK_DIS_STRAP} = 3'h0;
    t_regs(1'b0, 1'b0, 1'b0);
    t_regs(1'b1, 1'b1, 1'b1);
    t_mode1();
    t_mode2();
    t_mode3();
    t_pin();
    t_clk();
    final_report();
  end
endmodule
`default_nettype wire
